// ### core/ecs_pkg.sv
// Object map, encodings, timing and helpers for the encoder counter core
// Contract
// [RQ1] Modes 2 and 4 select quadrature encoder inputs, TTL or open collector
// [RQ2] Modes 3 and 5 select pulse counting with direction from track B
// [RQ3] Input type comes from the per-channel counter mode entry
// [RQ4] Single evaluation counts only rising edges of track A
// [RQ5] Double evaluation counts both edges of track A
// [RQ6] Quadruple evaluation counts both edges of tracks A and B; in modes 3 and 5 only the edges of track A are counted
// [RQ7] Evaluation defaults to quadruple after reset
// [RQ8] Evaluation multiplier is set by the per-channel evaluation entry
// [RQ9] Each channel's captured count is readable as input process data
// [RQ10] Supply selects 5 V, 12 V or 24 V via channel one; 5 V default
// [RQ11] Channel two supply entry writes have no effect
// [RQ12] Supply writes take effect only while the unlock word holds the pass value
// [RQ13] Frame-triggered mode captures process data on each passing frame
// [RQ14] Synchronous modes capture at constant intervals from the clock unit
// [RQ15] Output-oriented sync fires shortly after the frame passes
// [RQ16] Input-oriented sync fires before the next frame arrives
// [RQ17] A fast master watches the input cycle counter for fresh data
// [RQ18] Master should cycle at about 100 to 150 us for two channels
// [RQ19] Standard map uses 8-byte status and 6-byte control per channel
// [RQ20] Compact map uses 6-byte status and 4-byte control per channel
// [RQ21] Encoder counts up when A leads B, down when A lags B
// [RQ22] Pulse mode counts up with B low, down with B high
// [RQ23] Tracks pass two synchroniser stages before edge detection
// [RQ24] Both tracks changing at once in quadruple mode leaves count unchanged; in modes 3 and 5 the A edge is still counted
package ecs_pkg;
  localparam int CLK_MHZ = 250;
  localparam int OUT_SHIFT_NS = 1000;
  localparam int IN_LEAD_NS = 10000;
  localparam int REC_CYCLE_MIN_NS = 100000;
  localparam int REC_CYCLE_MAX_NS = 150000;
  localparam int OUT_SHIFT_CYC = (OUT_SHIFT_NS * CLK_MHZ + 999) / 1000;
  localparam int IN_LEAD_CYC = (IN_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DC_PERIOD_DEF_CYC = REC_CYCLE_MIN_NS * CLK_MHZ / 1000;

  localparam logic [15:0] OBJ_EVAL_CH1 = 16'h8000;
  localparam logic [15:0] OBJ_CFG_CH1 = 16'h8001;
  localparam logic [15:0] OBJ_CFG_CH2 = 16'h8011;
  localparam logic [15:0] OBJ_STAT_CH1 = 16'h6000;
  localparam logic [15:0] OBJ_CYCLE = 16'h6002;
  localparam logic [15:0] OBJ_CODE = 16'hF008;
  localparam logic [15:0] OBJ_CH_STRIDE = 16'h0010;
  localparam logic [7:0] SUB_EVAL = 8'h06;
  localparam logic [7:0] SUB_SUPPLY = 8'h17;
  localparam logic [7:0] SUB_CNT_MODE = 8'h1D;
  localparam logic [7:0] SUB_CNT_VAL = 8'h11;
  localparam logic [7:0] SUB_CYCLE = 8'h0F;
  localparam logic [7:0] SUB_CODE = 8'h00;
  localparam logic [31:0] CODE_PASS = 32'h72657375;

  localparam logic [2:0] CM_ENC_TTL = 3'h2;
  localparam logic [2:0] CM_CNT_TTL = 3'h3;
  localparam logic [2:0] CM_ENC_OC = 3'h4;
  localparam logic [2:0] CM_CNT_OC = 3'h5;
  localparam logic [2:0] CM_RESET = CM_ENC_TTL;
  localparam logic [1:0] EV_4X = 2'h0;
  localparam logic [1:0] EV_2X = 2'h1;
  localparam logic [1:0] EV_1X = 2'h2;
  localparam logic [1:0] EV_RESET = EV_4X;
  localparam logic [1:0] SUP_5V = 2'h0;
  localparam logic [1:0] SUP_24V = 2'h2;
  localparam logic [1:0] SUP_RESET = SUP_5V;
  localparam logic [1:0] SYNC_FRAME = 2'h0;
  localparam logic [1:0] SYNC_DC_OUT = 2'h1;
  localparam logic [1:0] SYNC_DC_IN = 2'h2;
  localparam logic [3:0] STD_STATUS_BYTES = 4'h8;
  localparam logic [3:0] STD_CONTROL_BYTES = 4'h6;
  localparam logic [3:0] CMP_STATUS_BYTES = 4'h6;
  localparam logic [3:0] CMP_CONTROL_BYTES = 4'h4;

  function automatic logic isCounterMode(input logic [2:0] mode);
    isCounterMode = (mode == CM_CNT_TTL) || (mode == CM_CNT_OC); // RQ2
  endfunction

  function automatic logic validCntMode(input logic [31:0] value);
    validCntMode = (value >= {29'h0, CM_ENC_TTL}) &&
      (value <= {29'h0, CM_CNT_OC}); // RQ1 RQ2
  endfunction
endpackage

// ### core/ecs_track_sync.sv
// Two-stage synchroniser and edge history for one pair of encoder tracks
`timescale 1ns/1ns
module ecs_track_sync
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Raw tracks
  input wire logic trackA,
  input wire logic trackB,
  // Synchronised tracks and their previous values
  output logic syncA,
  output logic syncB,
  output logic prevA,
  output logic prevB
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stage;
    logic [1:0] prev;
    logic [2:0] fill;
  } ecs_sync_st_t;

  ecs_sync_st_t st;
  ecs_sync_st_t next_st;

  always_comb begin
    next_st.meta = {trackB, trackA};
    next_st.stage = st.meta; // RQ23
    next_st.prev = st.stage;
    next_st.fill = {st.fill[1:0], 1'b1};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncA = st.stage[0];
  assign syncB = st.stage[1];
  // History follows the live level until it holds a real sample, so a
  // track that is high at reset release is not counted as an edge
  assign prevA = st.fill[2] ? st.prev[0] : st.stage[0];
  assign prevB = st.fill[2] ? st.prev[1] : st.stage[1];
endmodule

// ### core/ecs_channel.sv
// Edge evaluation and up/down count for one encoder channel
`timescale 1ns/1ns
module ecs_channel
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Synchronised tracks
  input wire logic trackA,
  input wire logic trackB,
  input wire logic prevA,
  input wire logic prevB,
  // Configuration
  input wire logic [2:0] cntMode,
  input wire logic [1:0] evalMode,
  // Live count
  output logic [31:0] count
);
  typedef struct packed {
    logic [31:0] count;
  } ecs_chan_st_t;

  ecs_chan_st_t st;
  ecs_chan_st_t next_st;
  logic aRise;
  logic aEdge;
  logic bEdge;
  logic step;
  logic up;

  always_comb begin
    aRise = trackA & ~prevA;
    aEdge = trackA ^ prevA;
    bEdge = trackB ^ prevB;
    next_st = st;
    step = 1'b0;
    up = 1'b1;
    if (isCounterMode(cntMode)) begin
      up = ~trackB; // RQ22
      step = (evalMode == EV_1X) ? aRise : aEdge;
    end else begin
      case (evalMode)
        EV_1X: step = aRise; // RQ4
        EV_2X: step = aEdge; // RQ5
        default: step = aEdge ^ bEdge; // RQ6 RQ24
      endcase
      up = aEdge ? (trackA != trackB) : (trackA == trackB); // RQ21
    end
    if (step) begin
      next_st.count = up ? st.count + 32'h1 : st.count - 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_ONE_X_RISE_ONLY: assert property ( // RQ4
    (evalMode == EV_1X && !(trackA && !prevA)) |=> $stable(count)
  ) else $error("count moved without a rising A edge in 1x");

  AST_TWO_X_BOTH: assert property ( // RQ5
    (evalMode == EV_2X && !isCounterMode(cntMode) && trackA != prevA)
      |=> count != $past(count)
  ) else $error("A edge not counted in 2x");

  AST_FOUR_X_INVALID: assert property ( // RQ24
    (evalMode == EV_4X && !isCounterMode(cntMode) &&
      trackA != prevA && trackB != prevB) |=> $stable(count)
  ) else $error("double track change was counted");

  AST_ENC_FORWARD: assert property ( // RQ21
    (!isCounterMode(cntMode) && trackA && !prevA && !trackB && !prevB)
      |=> count == $past(count) + 32'h1
  ) else $error("A leading B did not count up");

  AST_PULSE_REVERSE: assert property ( // RQ22
    (isCounterMode(cntMode) && trackA && !prevA && trackB)
      |=> count == $past(count) - 32'h1
  ) else $error("pulse with B high did not count down");
endmodule

// ### core/ecs_counter_core.sv
// Two-channel encoder counter with object access and sync-mode capture
`timescale 1ns/1ns
module ecs_counter_core
  import ecs_pkg::*;
#(
  parameter int DC_PERIOD_CYC = DC_PERIOD_DEF_CYC
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Encoder tracks, one bit per channel
  input wire logic [1:0] trackA,
  input wire logic [1:0] trackB,
  // Fieldbus frame events and sync setup
  input wire logic frameStart,
  input wire logic frameEnd,
  input wire logic [1:0] syncMode,
  input wire logic compactMap,
  // Object access port
  input wire logic objReq,
  input wire logic objWrite,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSub,
  input wire logic [31:0] objWrData,
  output logic objAck,
  output logic objErr,
  output logic [31:0] objRdData,
  // Input process data
  output logic [31:0] cntValue0,
  output logic [31:0] cntValue1,
  output logic [15:0] cycleCount,
  output logic capPulse,
  // Mapping sizes and encoder supply
  output logic [3:0] statusBytes,
  output logic [3:0] controlBytes,
  output logic [1:0] supplySel
);
  localparam logic [31:0] PERIOD_CNT = 32'(DC_PERIOD_CYC);
  localparam logic [31:0] PERIOD_LAST = 32'(DC_PERIOD_CYC - 1);
  localparam logic [31:0] OUT_FIRE = 32'(OUT_SHIFT_CYC);
  localparam logic [31:0] IN_FIRE = 32'(DC_PERIOD_CYC - IN_LEAD_CYC);
  localparam logic [31:0] SUP_MAX = {30'h0, SUP_24V};
  localparam logic [31:0] EV_MAX = {30'h0, EV_1X};

  typedef struct packed {
    logic [1:0][2:0] cntMode;
    logic [1:0][1:0] evalMode;
    logic [1:0] supply;
    logic [31:0] code;
    logic [1:0][31:0] cap;
    logic [15:0] cycle;
    logic [31:0] dcTimer;
    logic capPulse;
    logic ack;
    logic err;
    logic [31:0] rd;
    logic [3:0] stBytes;
    logic [3:0] ctBytes;
  } ecs_core_st_t;

  ecs_core_st_t st;
  ecs_core_st_t next_st;
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic [1:0] prevA;
  logic [1:0] prevB;
  logic [1:0][31:0] liveCount;
  logic refEvent;
  logic capture;
  logic [31:0] fireAt;
  logic [1:0] cfgHit;
  logic [1:0] evalHit;
  logic [1:0] statHit;

  // Hit flag in bit 1, channel number in bit 0
  function automatic logic [1:0] chanHit(input logic [15:0] idx,
                                         input logic [15:0] base);
    logic second;
    second = (idx == base + OBJ_CH_STRIDE);
    chanHit = {(idx == base) || second, second};
  endfunction

  for (genvar i = 0; i < 2; i++) begin : g_chan
    ecs_track_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .trackA(trackA[i]),
      .trackB(trackB[i]),
      .syncA(syncA[i]),
      .syncB(syncB[i]),
      .prevA(prevA[i]),
      .prevB(prevB[i])
    );
    ecs_channel u_chan (
      .core_clk(core_clk),
      .rst(rst),
      .trackA(syncA[i]),
      .trackB(syncB[i]),
      .prevA(prevA[i]),
      .prevB(prevB[i]),
      .cntMode(st.cntMode[i]), // RQ3
      .evalMode(st.evalMode[i]), // RQ8
      .count(liveCount[i])
    );
  end

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.capPulse = 1'b0;
    cfgHit = chanHit(objIndex, OBJ_CFG_CH1);
    evalHit = chanHit(objIndex, OBJ_EVAL_CH1);
    statHit = chanHit(objIndex, OBJ_STAT_CH1);

    // Clock-unit timer restarts on the frame edge that anchors the mode
    refEvent = (syncMode == SYNC_DC_IN) ? frameStart : frameEnd;
    fireAt = (syncMode == SYNC_DC_IN) ? IN_FIRE : OUT_FIRE; // RQ15 RQ16
    if (refEvent || st.dcTimer >= PERIOD_LAST) begin
      next_st.dcTimer = '0;
    end else begin
      next_st.dcTimer = st.dcTimer + 32'h1;
    end
    case (syncMode)
      SYNC_FRAME: capture = frameEnd; // RQ13
      SYNC_DC_OUT,
      SYNC_DC_IN: capture = !refEvent && st.dcTimer == fireAt; // RQ14
      default: capture = frameEnd;
    endcase
    if (capture) begin
      next_st.capPulse = 1'b1;
      next_st.cycle = st.cycle + 16'h1;
      for (int i = 0; i < 2; i++) begin
        next_st.cap[i] = compactMap ? {16'h0, liveCount[i][15:0]}
                                    : liveCount[i]; // RQ9
      end
    end

    next_st.stBytes = compactMap ? CMP_STATUS_BYTES
                                 : STD_STATUS_BYTES; // RQ19 RQ20
    next_st.ctBytes = compactMap ? CMP_CONTROL_BYTES
                                 : STD_CONTROL_BYTES; // RQ19 RQ20

    if (objReq) begin
      next_st.ack = 1'b1;
      next_st.rd = '0;
      if (objIndex == OBJ_CODE && objSub == SUB_CODE) begin
        if (objWrite) begin
          next_st.code = objWrData;
        end else begin
          next_st.rd = st.code;
        end
      end else if (cfgHit[1] && objSub == SUB_CNT_MODE) begin
        if (!objWrite) begin
          next_st.rd = {29'h0, st.cntMode[cfgHit[0]]};
        end else if (validCntMode(objWrData)) begin
          next_st.cntMode[cfgHit[0]] = objWrData[2:0]; // RQ3 RQ1
        end else begin
          next_st.err = 1'b1;
        end
      end else if (cfgHit[1] && objSub == SUB_SUPPLY) begin
        if (!objWrite) begin
          next_st.rd = {30'h0, st.supply};
        end else if (!cfgHit[0]) begin
          // Second channel's entry is accepted but steers nothing
          if (st.code == CODE_PASS && objWrData <= SUP_MAX) begin
            next_st.supply = objWrData[1:0]; // RQ10 RQ11 RQ12
          end else begin
            next_st.err = 1'b1;
          end
        end
      end else if (evalHit[1] && objSub == SUB_EVAL) begin
        if (!objWrite) begin
          next_st.rd = {30'h0, st.evalMode[evalHit[0]]};
        end else if (objWrData <= EV_MAX) begin
          next_st.evalMode[evalHit[0]] = objWrData[1:0]; // RQ8
        end else begin
          next_st.err = 1'b1;
        end
      end else if (statHit[1] && objSub == SUB_CNT_VAL && !objWrite) begin
        next_st.rd = st.cap[statHit[0]]; // RQ9
      end else if (objIndex == OBJ_CYCLE && objSub == SUB_CYCLE &&
                   !objWrite) begin
        next_st.rd = {16'h0, st.cycle};
      end else begin
        next_st.err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.cntMode <= {CM_RESET, CM_RESET};
      st.evalMode <= {EV_RESET, EV_RESET}; // RQ7
      st.supply <= SUP_RESET; // RQ10
      st.stBytes <= STD_STATUS_BYTES;
      st.ctBytes <= STD_CONTROL_BYTES;
    end else begin
      st <= next_st;
    end
  end

  assign objAck = st.ack;
  assign objErr = st.err;
  assign objRdData = st.rd;
  assign cntValue0 = st.cap[0];
  assign cntValue1 = st.cap[1];
  assign cycleCount = st.cycle;
  assign capPulse = st.capPulse;
  assign statusBytes = st.stBytes;
  assign controlBytes = st.ctBytes;
  assign supplySel = st.supply;

  // Cycles since the last anchoring frame edge, for the checks below
  logic [31:0] sinceRef;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sinceRef <= 32'hFFFFFFFF;
    end else if (refEvent) begin
      sinceRef <= '0;
    end else if (sinceRef != 32'hFFFFFFFF) begin
      sinceRef <= sinceRef + 32'h1;
    end
  end

  logic supWrite1;
  logic supWrite2;
  assign supWrite1 = objReq && objWrite && objIndex == OBJ_CFG_CH1 &&
                     objSub == SUB_SUPPLY;
  assign supWrite2 = objReq && objWrite && objIndex == OBJ_CFG_CH2 &&
                     objSub == SUB_SUPPLY;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SUP_LOCKED: assert property ( // RQ12
    (supWrite1 && st.code != CODE_PASS) |=> $stable(supplySel) && objErr
  ) else $error("supply changed without the unlock word");

  AST_SUP_CH2_IGNORED: assert property ( // RQ11
    supWrite2 |=> $stable(supplySel) && objAck && !objErr
  ) else $error("second channel supply write had an effect");

  AST_SUP_SET: assert property ( // RQ10
    (supWrite1 && st.code == CODE_PASS && objWrData <= SUP_MAX)
      |=> supplySel == $past(objWrData[1:0]) ##1
        ($past(supWrite1) || $stable(supplySel))
  ) else $error("unlocked supply write not applied");

  AST_MODE_SET: assert property ( // RQ3
    (objReq && objWrite && objIndex == OBJ_CFG_CH2 &&
      objSub == SUB_CNT_MODE && validCntMode(objWrData))
      |=> st.cntMode[1] == $past(objWrData[2:0]) && !objErr
  ) else $error("counter mode write not applied");

  AST_EVAL_SET: assert property ( // RQ8
    (objReq && objWrite && objIndex == OBJ_EVAL_CH1 &&
      objSub == SUB_EVAL && objWrData > EV_MAX)
      |=> $stable(st.evalMode) && objErr
  ) else $error("bad evaluation setting accepted");

  AST_FRAME_CAPTURE: assert property ( // RQ13
    (syncMode == SYNC_FRAME && frameEnd)
      |=> capPulse && cycleCount == $past(cycleCount) + 16'h1
  ) else $error("frame did not trigger capture");

  AST_DC_IGNORES_FRAME: assert property ( // RQ14
    (syncMode == SYNC_DC_OUT && frameEnd) |=> !capPulse
  ) else $error("frame triggered capture in clock-synchronous mode");

  AST_OUT_SYNC_AFTER: assert property ( // RQ15
    (capPulse && syncMode == SYNC_DC_OUT && $stable(syncMode) &&
      sinceRef < PERIOD_CNT) |-> sinceRef == OUT_FIRE + 32'h1
  ) else $error("output sync not at its shift after the frame");

  AST_IN_SYNC_BEFORE: assert property ( // RQ16
    (capPulse && syncMode == SYNC_DC_IN && $stable(syncMode) &&
      sinceRef < PERIOD_CNT) |-> sinceRef == IN_FIRE + 32'h1
  ) else $error("input sync not ahead of the next frame");

  AST_PDO_SIZES: assert property ( // RQ19 RQ20
    compactMap |=> statusBytes == CMP_STATUS_BYTES &&
      controlBytes == CMP_CONTROL_BYTES
  ) else $error("compact map sizes wrong");

  COV_FRAME_CAPTURE: cover property (
    syncMode == SYNC_FRAME && frameEnd ##1 capPulse
  );

  COV_OUT_SYNC: cover property (
    syncMode == SYNC_DC_OUT && capPulse
  );

  COV_SUPPLY_UNLOCKED: cover property (
    supWrite1 && st.code == CODE_PASS ##1 supplySel != SUP_5V
  );
endmodule

// ### sim/ecs_enc_model.sv
// Track generator standing in for one encoder or pulse source
`timescale 1ns/1ns
module ecs_enc_model (
  // Clock
  input wire logic core_clk,
  // Commands from the bench
  input wire logic step,
  input wire logic dir,
  input wire logic pulseMode,
  input wire logic glitch,
  // Track levels
  output logic trackA,
  output logic trackB
);
  initial begin
    trackA = 1'b0;
    trackB = 1'b0;
  end

  always @(posedge core_clk) begin
    if (pulseMode) begin
      trackB <= dir;
      if (step) begin
        trackA <= ~trackA;
      end
    end else if (glitch) begin
      // Both tracks at once, an illegal step
      trackA <= ~trackA;
      trackB <= ~trackB;
    end else if (step) begin
      if ((trackA == trackB) != dir) begin
        trackA <= ~trackA;
      end else begin
        trackB <= ~trackB;
      end
    end
  end
endmodule

// ### sim/ecs_counter_core_tb_top.sv
// Self-checking bench for the two-channel encoder counter core
`timescale 1ns/1ns
module ecs_counter_core_tb_top
  import ecs_pkg::*;
;
  // Far below the recommended master cycle to keep the run short, so
  // every capture is tracked through the cycle counter instead
  localparam int DCP = 3000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire logic [1:0] trackA;
  wire logic [1:0] trackB;
  logic [1:0] step = 2'h0;
  logic [1:0] glitch = 2'h0;
  logic [1:0] pulseMode = 2'h0;
  logic dir = 1'b0;
  logic frameStart = 1'b0;
  logic frameEnd = 1'b0;
  logic [1:0] syncMode = 2'h0;
  logic compactMap = 1'b0;
  logic objReq = 1'b0;
  logic objWrite = 1'b0;
  logic [15:0] objIndex = 16'h0;
  logic [7:0] objSub = 8'h0;
  logic [31:0] objWrData = 32'h0;
  logic objAck;
  logic objErr;
  logic [31:0] objRdData;
  logic [31:0] cntValue0;
  logic [31:0] cntValue1;
  logic [15:0] cycleCount;
  logic capPulse;
  logic [3:0] statusBytes;
  logic [3:0] controlBytes;
  logic [1:0] supplySel;
  logic [31:0] expCnt [2];
  logic [15:0] expCyc;
  int mismatches = 0;
  int compares = 0;

  always #2 core_clk = ~core_clk;

  ecs_counter_core #(.DC_PERIOD_CYC(DCP)) ecs_counter_core_inst (
    .core_clk(core_clk), .rst(rst), .trackA(trackA), .trackB(trackB),
    .frameStart(frameStart), .frameEnd(frameEnd), .syncMode(syncMode),
    .compactMap(compactMap), .objReq(objReq), .objWrite(objWrite),
    .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData),
    .objAck(objAck), .objErr(objErr), .objRdData(objRdData),
    .cntValue0(cntValue0), .cntValue1(cntValue1),
    .cycleCount(cycleCount), .capPulse(capPulse),
    .statusBytes(statusBytes), .controlBytes(controlBytes),
    .supplySel(supplySel));

  for (genvar c = 0; c < 2; c++) begin : gEnc
    ecs_enc_model ecs_enc_model_inst (
      .core_clk(core_clk), .step(step[c]), .dir(dir),
      .pulseMode(pulseMode[c]), .glitch(glitch[c]),
      .trackA(trackA[c]), .trackB(trackB[c]));
  end

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic stuck(input string name);
    mismatches++;
    $display("ERROR %s expected pulse seen none", name);
    end_of_test();
  endtask

  task automatic obj(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] data, input logic err,
      output logic [31:0] rd);
    int i;
    @(negedge core_clk);
    objReq = 1'b1;
    objWrite = wr;
    objIndex = idx;
    objSub = sub;
    objWrData = data;
    @(negedge core_clk);
    objReq = 1'b0;
    for (i = 0; i < 4 && objAck !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    if (objAck !== 1'b1) begin
      stuck("objAck");
    end
    // Ack already stands in the cycle right after the request
    check("objLatency", 32'(i), 32'h0);
    check("objErr", {31'h0, objErr}, {31'h0, err});
    rd = objRdData;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] data, input logic err);
    logic [31:0] rd;
    obj(1'b1, idx, sub, data, err, rd);
  endtask

  task automatic rdChk(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] exp);
    logic [31:0] rd;
    obj(1'b0, idx, sub, 32'h0, 1'b0, rd);
    check("objRdData", rd, exp);
  endtask

  task automatic move(input int ch, input int n, input logic d);
    dir = d;
    repeat (4) @(negedge core_clk);
    repeat (n) begin
      step[ch] = 1'b1;
      @(negedge core_clk);
      step[ch] = 1'b0;
      repeat (7) @(negedge core_clk);
    end
  endtask

  task automatic pulse(input logic startEv);
    @(negedge core_clk);
    frameStart = startEv;
    frameEnd = ~startEv;
  endtask

  task automatic waitCap(input logic [31:0] exp);
    int n;
    n = 0;
    // The frame pulse is lowered here, one cycle after it was raised
    do begin
      @(negedge core_clk);
      frameStart = 1'b0;
      frameEnd = 1'b0;
      n++;
    end while (capPulse !== 1'b1 && n < 4000);
    if (capPulse !== 1'b1) begin
      stuck("capPulse");
    end
    expCyc++;
    check("capDelay", 32'(n), exp);
    check("cycleCount", {16'h0, cycleCount}, {16'h0, expCyc});
  endtask

  task automatic cap();
    logic [31:0] m;
    m = compactMap ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    pulse(1'b0);
    waitCap(32'h1);
    check("cntValue0", cntValue0, expCnt[0] & m);
    check("cntValue1", cntValue1, expCnt[1] & m);
  endtask

  task automatic sizes(input logic [3:0] st, input logic [3:0] ct);
    check("statusBytes", {28'h0, statusBytes}, {28'h0, st});
    check("controlBytes", {28'h0, controlBytes}, {28'h0, ct});
  endtask

  task automatic testReset();
    sizes(4'h8, 4'h6);
    check("supplySel", {30'h0, supplySel}, 32'h0);
    rdChk(OBJ_EVAL_CH1, SUB_EVAL, {30'h0, EV_4X});
    rdChk(OBJ_CFG_CH2, SUB_CNT_MODE, 32'h2);
    wr(OBJ_CFG_CH2, SUB_CNT_MODE, 32'h4, 1'b0);
    rdChk(OBJ_CFG_CH2, SUB_CNT_MODE, 32'h4);
    wr(OBJ_STAT_CH1, SUB_CNT_VAL, 32'h5, 1'b1);
    wr(16'h8002, 8'h00, 32'h0, 1'b1);
  endtask

  task automatic testSupply();
    wr(OBJ_CFG_CH1, SUB_SUPPLY, 32'h2, 1'b1);
    check("supplySel", {30'h0, supplySel}, 32'h0);
    wr(OBJ_CODE, SUB_CODE, CODE_PASS, 1'b0);
    rdChk(OBJ_CODE, SUB_CODE, CODE_PASS);
    for (int v = 0; v < 3; v++) begin
      wr(OBJ_CFG_CH1, SUB_SUPPLY, 32'(v), 1'b0);
      check("supplySel", {30'h0, supplySel}, 32'(v));
    end
    wr(OBJ_CFG_CH2, SUB_SUPPLY, 32'h1, 1'b0);
    check("supplySel", {30'h0, supplySel}, 32'h2);
    rdChk(OBJ_CFG_CH2, SUB_SUPPLY, 32'h2);
    wr(OBJ_CFG_CH1, SUB_SUPPLY, 32'h3, 1'b1);
    wr(OBJ_CODE, SUB_CODE, 32'h0, 1'b0);
    wr(OBJ_CFG_CH1, SUB_SUPPLY, 32'h0, 1'b1);
    check("supplySel", {30'h0, supplySel}, 32'h2);
  endtask

  task automatic testEval();
    for (int e = 0; e < 3; e++) begin
      wr(OBJ_EVAL_CH1, SUB_EVAL, 32'(e), 1'b0);
      wr(OBJ_EVAL_CH1 + OBJ_CH_STRIDE, SUB_EVAL, 32'(e), 1'b0);
      move(0, 4, 1'b0);
      move(1, 4, 1'b1);
      expCnt[0] += 32'(4 >> e);
      expCnt[1] -= 32'(4 >> e);
      cap();
    end
    wr(OBJ_EVAL_CH1, SUB_EVAL, 32'h3, 1'b1);
    wr(OBJ_EVAL_CH1, SUB_EVAL, 32'h0, 1'b0);
    rdChk(OBJ_STAT_CH1 + OBJ_CH_STRIDE, SUB_CNT_VAL, expCnt[1]);
    rdChk(OBJ_CYCLE, SUB_CYCLE, {16'h0, expCyc});
  endtask

  task automatic testModes();
    logic [2:0] modes [4];
    modes = '{CM_ENC_TTL, CM_ENC_OC, CM_CNT_TTL, CM_CNT_OC};
    foreach (modes[k]) begin
      wr(OBJ_CFG_CH1, SUB_CNT_MODE, {29'h0, modes[k]}, 1'b0);
      pulseMode[0] = modes[k][0];
      move(0, 4, 1'b0);
      expCnt[0] += 32'h4;
      cap();
      move(0, 4, 1'b1);
      expCnt[0] -= 32'h4;
      cap();
    end
    move(0, 0, 1'b0);
    pulseMode[0] = 1'b0;
    wr(OBJ_CFG_CH1, SUB_CNT_MODE, 32'h6, 1'b1);
    wr(OBJ_CFG_CH1, SUB_CNT_MODE, 32'h2, 1'b0);
  endtask

  task automatic testGlitch();
    repeat (2) begin
      @(negedge core_clk);
      glitch[0] = 1'b1;
      @(negedge core_clk);
      glitch[0] = 1'b0;
      repeat (8) @(negedge core_clk);
      cap();
    end
  endtask

  task automatic testMaps();
    compactMap = 1'b1;
    move(0, 9, 1'b1);
    expCnt[0] -= 32'h9;
    sizes(4'h6, 4'h4);
    cap();
    compactMap = 1'b0;
    repeat (2) @(negedge core_clk);
    sizes(4'h8, 4'h6);
  endtask

  task automatic testSync();
    syncMode = 2'h1;
    pulse(1'b0);
    waitCap(32'(OUT_SHIFT_CYC + 2));
    waitCap(32'(DCP));
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    syncMode = 2'h2;
    rst = 1'b0;
    expCyc = 16'h0;
    check("supplySel", {30'h0, supplySel}, 32'h0);
    pulse(1'b1);
    waitCap(32'(DCP - IN_LEAD_CYC + 2));
    waitCap(32'(DCP));
  endtask

  initial begin
    expCnt[0] = 32'h0;
    expCnt[1] = 32'h0;
    expCyc = 16'h0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    testReset();
    testSupply();
    testEval();
    testModes();
    testGlitch();
    testMaps();
    testSync();
    end_of_test();
  end
endmodule
